// ---- hw/ebc_defines.vh ----
// constants for the external memory bus control block
// assumes a single 100 MHz core clock and an AXI4-Lite register port
//
// What this block does
// R1: 28 pins on four general ports: three address/data, one strobe
// R2: twenty lines; lines 0-15 carry address or data, 16-19 address only
// R3: eight strobes: latch, oe, two writes, byte bit, chip, two byte enables
// R4: data width 8 or 16 bits; address width 8, 12, 16 or 20 bits
// R5: in single-chip mode the control register ignores every write
// R6: bus-disable bit clear keeps the bus on and port functions off
// R7: bus-disable bit set gives pins to ports except during external accesses
// R8: bus-disable bit resets to zero, bus enabled
// R9: wait field bits 5-4: 11,10,01,00 give 0,1,2,3 instruction cycles
// R10: write-mode field bits 1-0 act only with 16-bit data width
// R11: word write outputs both latch bytes, high strobe on the odd byte
// R12: byte select: byte on both halves, high strobe plus one byte enable
// R13: idle bus: lines released, enables and strobes high, latch and bit low
// R14: external-only mode keeps the bus active and ignores the bus-disable bit
// R15: bus-disable set from external code acts once internal code runs
// R16: the bus outranks every other function sharing its pins
// R17: bits 6,3,2 read zero; write mode 00 is byte write with two strobes
// R18: the external memory finishes within base cycle plus inserted waits
`ifndef EBC_DEFINES_VH
`define EBC_DEFINES_VH
// ****************************************************************
// register map
// ****************************************************************
`define EBC_CTRL_OFS      4'h0
`define EBC_STAT_OFS      4'h4
`define EBC_CTRL_RESET    8'h00
`define EBC_CTRL_WMASK    8'hb3
`define EBC_DIS_BIT       7
`define EBC_WAIT_HI       5
`define EBC_WAIT_LO       4
`define EBC_WM_HI         1
`define EBC_WM_LO         0
// ****************************************************************
// program memory modes and address widths
// ****************************************************************
`define EBC_MODE_SINGLE   2'h0
`define EBC_MODE_EXTONLY  2'h1
`define EBC_ADW_8         2'h0
`define EBC_ADW_12        2'h1
`define EBC_ADW_16        2'h2
// ****************************************************************
// timing: one instruction cycle in clocks (10 ns clock, 40 ns cycle)
// ****************************************************************
`define EBC_TCY_NS        40
`define EBC_CLK_NS        10
`define EBC_TCY_CLKS      ((`EBC_TCY_NS + `EBC_CLK_NS - 1) / `EBC_CLK_NS)
// clocks after the data phase before the read byte has crossed the
// pad register and the three-stage input synchroniser
`define EBC_SYNC_WAIT     8'h03
`endif

// ---- hw/ebc_top.v ----
// external memory bus control: control register, pin ownership and
// table read/write bus cycles
// assumes core request signals on aclk; bus pins come from outside
`include "ebc_defines.vh"
`default_nettype none
module ebc_top
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [1:0]  prog_mode,
  input  wire        data_width_16,
  input  wire [1:0]  addr_width,
  input  wire        core_exec_ext,
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [20:0] req_addr,
  input  wire [7:0]  table_latch,
  output reg         req_done,
  output reg         req_err,
  output reg  [7:0]  req_rdata,
  input  wire [15:0] gp_ad_o,
  input  wire [15:0] gp_ad_oe,
  input  wire [3:0]  gp_hi_o,
  input  wire [3:0]  gp_hi_oe,
  input  wire [7:0]  gp_ctl_o,
  input  wire [7:0]  gp_ctl_oe,
  input  wire [15:0] pin_ad_i,
  output reg  [15:0] pin_ad_o,
  output reg  [15:0] pin_ad_oe,
  output reg  [3:0]  pin_hi_o,
  output reg  [3:0]  pin_hi_oe,
  output reg  [7:0]  pin_ctl_o,
  output reg  [7:0]  pin_ctl_oe
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_ADDR = 2'h1;
  localparam [1:0] S_DATA = 2'h2;
  localparam [1:0] S_END  = 2'h3;
  localparam integer TCY_I  = `EBC_TCY_CLKS;
  localparam [7:0] TCY    = TCY_I[7:0];

  // ****************************************************************
  // control register and AXI4-Lite slave
  // ****************************************************************
  reg  [7:0]  ctrl_q;
  reg         dis_eff_q;
  reg  [1:0]  state_q;
  reg  [7:0]  cnt_q;
  wire        wsel   = (s_axi_awaddr == `EBC_CTRL_OFS);
  wire        wmap   = wsel || (s_axi_awaddr == `EBC_STAT_OFS);
  wire        rmap_c = (s_axi_araddr == `EBC_CTRL_OFS);
  wire        rmap_s = (s_axi_araddr == `EBC_STAT_OFS);
  wire        single = (prog_mode == `EBC_MODE_SINGLE);
  wire        extonly = (prog_mode == `EBC_MODE_EXTONLY);
  wire        wtake  = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  wire        rtake  = s_axi_arready && s_axi_arvalid;
  wire        bus_active;
  reg  [7:0]  rd_byte_q;

  // write channel: both address and data taken in the same cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      ctrl_q        <= `EBC_CTRL_RESET; // R8 R9
    end
    else
    begin
      s_axi_awready <= !s_axi_awready && !s_axi_bvalid &&
                       s_axi_awvalid && s_axi_wvalid;
      s_axi_wready  <= !s_axi_awready && !s_axi_bvalid &&
                       s_axi_awvalid && s_axi_wvalid;
      if (wtake)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wmap ? 2'h0 : 2'h2;
        // reserved bits masked; single-chip mode blocks writes
        if (wsel && s_axi_wstrb[0] && !single) // R5
          ctrl_q <= s_axi_wdata[7:0] & `EBC_CTRL_WMASK; // R17
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: control register and status word
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rtake)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= (rmap_c || rmap_s) ? 2'h0 : 2'h2;
        if (rmap_c)
          s_axi_rdata <= {24'h000000, ctrl_q}; // R17
        else if (rmap_s)
          s_axi_rdata <= {16'h0000, rd_byte_q, 3'h0, dis_eff_q,
                          state_q, bus_active, (state_q != S_IDLE)};
        else
          s_axi_rdata <= 32'h00000000;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // pin ownership
  // ****************************************************************
  // disable bit takes effect only while running from internal memory
  always @(posedge aclk)
  begin
    if (!aresetn)
      dis_eff_q <= 1'b0;
    else if (!core_exec_ext)
      dis_eff_q <= ctrl_q[`EBC_DIS_BIT]; // R15
  end

  assign bus_active = extonly || // R14
                      (!single && (!dis_eff_q || core_exec_ext || // R6
                                   (state_q != S_IDLE))); // R7

  // number of address lines in use for the chosen address width
  reg  [4:0]  addr_bits;
  always @*
  begin
    case (addr_width) // R4
      `EBC_ADW_8:  addr_bits = 5'd8;
      `EBC_ADW_12: addr_bits = 5'd12;
      `EBC_ADW_16: addr_bits = 5'd16;
      default:     addr_bits = 5'd20;
    endcase
  end

  // ****************************************************************
  // pin input synchroniser: three stages, change when 2 and 3 agree
  // ****************************************************************
  reg  [15:0] ad_s1_q;
  reg  [15:0] ad_s2_q;
  reg  [15:0] ad_s3_q;
  reg  [15:0] ad_in_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ad_s1_q <= 16'h0000;
      ad_s2_q <= 16'h0000;
      ad_s3_q <= 16'h0000;
      ad_in_q <= 16'h0000;
    end
    else
    begin
      ad_s1_q <= pin_ad_i;
      ad_s2_q <= ad_s1_q;
      ad_s3_q <= ad_s2_q;
      if (ad_s2_q == ad_s3_q)
        ad_in_q <= ad_s3_q;
    end
  end

  // ****************************************************************
  // table access sequencer
  // ****************************************************************
  reg         wr_q;
  reg  [20:0] addr_q;
  reg  [7:0]  byte_q;
  reg  [7:0]  even_q;
  wire [1:0]  wm     = ctrl_q[`EBC_WM_HI:`EBC_WM_LO];
  wire [1:0]  waitf  = ctrl_q[`EBC_WAIT_HI:`EBC_WAIT_LO];
  wire [7:0]  data_len = TCY + TCY * {6'h00, ~waitf}; // R9
  // word-mode even byte only loads the holding latch
  wire        hold_only = req_write && data_width_16 &&
                          wm[1] && !req_addr[0]; // R11

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q   <= S_IDLE;
      cnt_q     <= 8'h00;
      wr_q      <= 1'b0;
      addr_q    <= 21'h000000;
      byte_q    <= 8'h00;
      even_q    <= 8'h00;
      rd_byte_q <= 8'h00;
      req_done  <= 1'b0;
      req_err   <= 1'b0;
      req_rdata <= 8'h00;
    end
    else
    begin
      req_done <= 1'b0;
      req_err  <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (req_valid && !req_done)
          begin
            if (single)
            begin
              req_done <= 1'b1;
              req_err  <= 1'b1;
            end
            else if (hold_only)
            begin
              even_q   <= table_latch;
              req_done <= 1'b1;
            end
            else
            begin
              wr_q    <= req_write;
              addr_q  <= req_addr;
              byte_q  <= table_latch;
              cnt_q   <= TCY - 8'h01;
              state_q <= S_ADDR;
            end
          end
        end
        S_ADDR:
        begin
          if (cnt_q == 8'h00)
          begin
            cnt_q   <= data_len - 8'h01;
            state_q <= S_DATA;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        end
        S_DATA:
        begin
          // memory answers within the wait-extended data phase
          if (cnt_q == 8'h00) // R18
          begin
            cnt_q   <= `EBC_SYNC_WAIT;
            state_q <= S_END;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        end
        S_END:
        begin
          // wait out pad lag and synchroniser so even zero-wait reads
          // take the byte the memory drove, not the released lines
          if (cnt_q == 8'h00)
          begin
            if (!wr_q)
            begin
              rd_byte_q <= (data_width_16 && addr_q[0]) ?
                           ad_in_q[15:8] : ad_in_q[7:0];
              req_rdata <= (data_width_16 && addr_q[0]) ?
                           ad_in_q[15:8] : ad_in_q[7:0];
            end
            req_done <= 1'b1;
            state_q  <= S_IDLE;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // bus pin values per phase
  // ****************************************************************
  // ctl bits: 0 latch, 1 oe_n, 2 wrl_n, 3 wrh_n, 4 ba0, 5 ce_n,
  // 6 lb_n, 7 ub_n
  reg  [15:0] bus_ad;
  reg         bus_ad_en;
  reg  [7:0]  bus_ctl; // R3
  always @*
  begin
    bus_ad    = addr_q[16:1];
    bus_ad_en = 1'b0;
    bus_ctl   = 8'hee; // R13
    case (state_q)
      S_ADDR:
      begin
        bus_ad_en = 1'b1;
        bus_ctl   = {3'h7, addr_q[0], 3'h7, 1'b1};
      end
      S_DATA:
      begin
        bus_ctl[5] = 1'b0;
        bus_ctl[4] = addr_q[0];
        if (!wr_q)
        begin
          bus_ctl[1] = 1'b0;
          bus_ctl[7] = 1'b0;
          bus_ctl[6] = 1'b0;
        end
        else if (!data_width_16) // R10
        begin
          bus_ad_en  = 1'b1;
          bus_ad     = {8'h00, byte_q};
          bus_ctl[2] = 1'b0;
        end
        else if (wm[1])
        begin
          bus_ad_en  = 1'b1;
          bus_ad     = {byte_q, even_q};
          bus_ctl[3] = 1'b0; // R11
          bus_ctl[7] = 1'b0;
          bus_ctl[6] = 1'b0;
        end
        else if (wm[0])
        begin
          bus_ad_en  = 1'b1;
          bus_ad     = {byte_q, byte_q};
          bus_ctl[3] = 1'b0; // R12
          bus_ctl[7] = !addr_q[0];
          bus_ctl[6] = addr_q[0];
        end
        else
        begin
          bus_ad_en  = 1'b1;
          bus_ad     = {byte_q, byte_q};
          bus_ctl[3] = !addr_q[0]; // R17
          bus_ctl[2] = addr_q[0];
        end
      end
      default:
        bus_ctl = 8'hee;
    endcase
  end

  // ****************************************************************
  // pin multiplexers: the bus outranks ports and peripherals
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_ad
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          pin_ad_o[gi]  <= 1'b0;
          pin_ad_oe[gi] <= 1'b0;
        end
        else if (bus_active && (gi < addr_bits)) // R1 R2 R16
        begin
          pin_ad_o[gi]  <= bus_ad[gi];
          pin_ad_oe[gi] <= bus_ad_en;
        end
        else
        begin
          pin_ad_o[gi]  <= gp_ad_o[gi];
          pin_ad_oe[gi] <= gp_ad_oe[gi];
        end
      end
    end
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_hi
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          pin_hi_o[gi]  <= 1'b0;
          pin_hi_oe[gi] <= 1'b0;
        end
        else if (bus_active && (addr_bits == 5'd20)) // R2 R16
        begin
          pin_hi_o[gi]  <= addr_q[17 + gi];
          pin_hi_oe[gi] <= (state_q != S_IDLE);
        end
        else
        begin
          pin_hi_o[gi]  <= gp_hi_o[gi];
          pin_hi_oe[gi] <= gp_hi_oe[gi];
        end
      end
    end
  endgenerate

  // control strobes: always driven while the bus owns the pins
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_ctl_o  <= 8'hee;
      pin_ctl_oe <= 8'hff;
    end
    else if (bus_active) // R16
    begin
      pin_ctl_o  <= bus_ctl;
      pin_ctl_oe <= 8'hff;
    end
    else
    begin
      pin_ctl_o  <= gp_ctl_o;
      pin_ctl_oe <= gp_ctl_oe;
    end
  end

endmodule
`default_nettype wire

// ---- verif/ebc_mem_model.sv ----
// external parallel memory stand-in on the bus pins
// assumes the pin outputs of ebc_top on the same clock
`default_nettype none
module ebc_mem_model (
  input  wire logic        aclk,
  input  wire logic [15:0] pin_ad_o,
  input  wire logic [3:0]  pin_hi_o,
  input  wire logic [7:0]  pin_ctl_o,
  output wire logic [15:0] pin_ad_i,
  output var  logic [19:0] mem_a,
  output var  logic [15:0] mem_wd,
  output var  logic [7:0]  mem_ws
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************
  // memory behaviour
  // ********************************************************
  logic [15:0] last_q = 16'h0;
  wire logic   rd_on = !pin_ctl_o[1] && !pin_ctl_o[5];
  // answers at once; released lines show the inverse of the last word
  assign pin_ad_i = rd_on ? (mem_a[15:0] ^ 16'h5a3c) : ~last_q;
  // latch the address, capture write data and strobes
  always @(posedge aclk)
  begin
    if (pin_ctl_o[0]) mem_a <= {pin_hi_o, pin_ad_o};
    if (!pin_ctl_o[2] || !pin_ctl_o[3])
    begin
      mem_wd <= pin_ad_o;
      mem_ws <= pin_ctl_o;
    end
    if (rd_on) last_q <= pin_ad_i;
  end
endmodule
`default_nettype wire

// ---- verif/ebc_top_props_props.sv ----
// port checker for the external bus control block
// assumes binding onto ebc_top, one clock, sync active-low reset
`default_nettype none
module ebc_top_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  prog_mode,
  input wire logic        req_valid,
  input wire logic        req_done,
  input wire logic        req_err,
  input wire logic [15:0] pin_ad_oe,
  input wire logic [7:0]  pin_ctl_o,
  input wire logic [7:0]  pin_ctl_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************
  // properties
  // ********************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // external-only mode in force
  sequence s_ext;
    prog_mode == 2'h1;
  endsequence
  // no request for three cycles in external-only mode
  sequence s_quiet;
    (prog_mode == 2'h1 && !req_valid) [*3];
  endsequence
  a_done_pulse: assert property (req_done |=> !req_done)
    else $error("done held past one cycle");
  a_done_bound: assert property (
    $rose(req_valid) |-> ##[1:25] req_done)
    else $error("table access too slow");
  a_err_mode: assert property (
    req_done |-> req_err == (prog_mode == 2'h0))
    else $error("error flag does not match mode");
  a_aw_answer: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing");
  a_write_strb: assert property (
    s_ext ##0 (!pin_ctl_o[2] || !pin_ctl_o[3])
    |-> pin_ctl_o[1] && !pin_ctl_o[0])
    else $error("write strobe with read or latch");
  a_read_free: assert property (
    s_ext ##0 !pin_ctl_o[1]
    |-> pin_ad_oe == 16'h0 && pin_ctl_o[3:2] == 2'h3)
    else $error("lines driven during read");
  a_latch_addr: assert property (
    s_ext ##0 pin_ctl_o[0]
    |-> pin_ctl_o[5] && pin_ad_oe == 16'hffff)
    else $error("address phase malformed");
  a_idle_pins: assert property (
    s_quiet |-> pin_ctl_o == 8'hee
    && pin_ad_oe == 16'h0 && pin_ctl_oe == 8'hff)
    else $error("idle bus pins wrong");
endmodule
bind ebc_top ebc_top_props u_ebc_top_props (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_awready (s_axi_awready),
  .s_axi_bvalid  (s_axi_bvalid),
  .prog_mode     (prog_mode),
  .req_valid     (req_valid),
  .req_done      (req_done),
  .req_err       (req_err),
  .pin_ad_oe     (pin_ad_oe),
  .pin_ctl_o     (pin_ctl_o),
  .pin_ctl_oe    (pin_ctl_oe)
);
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the external bus control block
// assumes ebc_top, ebc_mem_model and the bound checker
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************
  // signals and instances
  // ********************************************************
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0]  s_axi_wstrb = 4'hf, gp_hi_o = 4'h9, gp_hi_oe = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, data_width_16 = 1'b1;
  logic        core_exec_ext = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [1:0]  prog_mode = 2'h1, addr_width = 2'h3;
  logic [20:0] req_addr = 21'h0, a;
  logic [7:0]  table_latch = 8'h0, gp_ctl_o = 8'hfe, gp_ctl_oe = 8'h0f;
  logic [15:0] gp_ad_o = 16'hc3a5, gp_ad_oe = 16'hffff, w;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, req_done, req_err, e;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  req_rdata, pin_ctl_o, pin_ctl_oe, mem_ws;
  logic [15:0] pin_ad_i, pin_ad_o, pin_ad_oe, mem_wd;
  logic [3:0]  pin_hi_o, pin_hi_oe;
  logic [19:0] mem_a;
  int          err_count = 0, compares = 0, n;
  ebc_top       u_ebc_top (.*);
  ebc_mem_model u_ebc_mem_model (.*);
  // clock
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  // ********************************************************
  // tasks
  // ********************************************************
  task automatic chk(input string nm, input logic [31:0] s, x);
    compares++;
    if (s !== x)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, r);
  endtask
  task automatic rd(input logic [3:0] ad, input logic [31:0] x,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, x);
    chk("rresp", s_axi_rresp, r);
  endtask
  // table access; n ends as cycles from the edge that raises req_valid to done
  task automatic tbl(input logic wt, input logic [20:0] ad,
                     input logic [7:0] d);
    @(posedge aclk);
    req_valid <= 1'b1;
    req_write <= wt;
    req_addr <= ad;
    table_latch <= d;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (req_done !== 1'b1 && n < 100);
    chk("req done", req_done, 1'b1);
    e = req_err;
    n = n - 1;
    @(posedge aclk);
    req_valid <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #200us;
    err_count++;
    end_of_test();
  end
  // ********************************************************
  // test sequence
  // ********************************************************
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("ctl pins", pin_ctl_o, 8'hee);
    rd(4'h0, 32'h0, 2'h0);
    wr(4'h0, 32'hffffffff, 2'h0);
    rd(4'h0, 32'hb3, 2'h0);
    wr(4'h8, 32'h5, 2'h2);
    rd(4'hc, 32'h0, 2'h2);
    $display("register test done");
    for (int c = 0; c < 4; c++)
    begin
      a = 21'h12345 + (c << 17);
      w = a[16:1] ^ 16'h5a3c;
      wr(4'h0, 32'h2 + (c << 4), 2'h0);
      tbl(1'b0, a, 8'h0);
      chk("latency", n, 9 + 4 * (4 - c));
      chk("rbyte", req_rdata, w[15:8]);
      chk("addr", mem_a, {a[20:17], a[16:1]});
    end
    $display("wait state test done");
    wr(4'h0, 32'h32, 2'h0);
    tbl(1'b1, 21'h100, 8'h34);
    chk("even", n, 1);
    tbl(1'b1, 21'h101, 8'h12);
    chk("wword", mem_wd, 16'h1234);
    chk("wstrb", mem_ws, 8'h16);
    wr(4'h0, 32'h31, 2'h0);
    tbl(1'b1, 21'h203, 8'ha5);
    chk("wword", mem_wd, 16'ha5a5);
    chk("wstrb", mem_ws, 8'h56);
    wr(4'h0, 32'h30, 2'h0);
    tbl(1'b1, 21'h204, 8'h5c);
    chk("wword", mem_wd, 16'h5c5c);
    chk("wstrb", mem_ws[5:0], 6'h0a);
    data_width_16 <= 1'b0;
    wr(4'h0, 32'h32, 2'h0);
    tbl(1'b1, 21'h300, 8'h77);
    chk("wlow", mem_wd[7:0], 8'h77);
    chk("wstrb", mem_ws[5:0], 6'h0a);
    data_width_16 <= 1'b1;
    $display("write mode test done");
    prog_mode <= 2'h2;
    wr(4'h0, 32'hb0, 2'h0);
    repeat (4) @(posedge aclk);
    chk("ad pins", pin_ad_o, gp_ad_o);
    chk("ctl oe", pin_ctl_oe, gp_ctl_oe);
    tbl(1'b0, 21'h0a5a6, 8'h0);
    chk("addr", mem_a, 20'h052d3);
    wr(4'h0, 32'h30, 2'h0);
    repeat (4) @(posedge aclk);
    chk("ctl pins", pin_ctl_o, 8'hee);
    chk("ad oe", pin_ad_oe, 16'h0);
    core_exec_ext <= 1'b1;
    wr(4'h0, 32'hb0, 2'h0);
    repeat (4) @(posedge aclk);
    chk("ctl oe", pin_ctl_oe, 8'hff);
    rd(4'h4, 32'h0000ef02, 2'h0);
    core_exec_ext <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("ctl oe", pin_ctl_oe, gp_ctl_oe);
    prog_mode <= 2'h1;
    repeat (4) @(posedge aclk);
    chk("ctl oe", pin_ctl_oe, 8'hff);
    $display("pin ownership test done");
    prog_mode <= 2'h0;
    wr(4'h0, 32'h1, 2'h0);
    rd(4'h0, 32'hb0, 2'h0);
    tbl(1'b1, 21'h10, 8'h1);
    chk("err", e, 1'b1);
    chk("latency", n, 1);
    $display("single chip test done");
    end_of_test();
  end
endmodule
`default_nettype wire
